// ### rtl/rss_sequencer.sv
// Our own choices: the AHB-Lite slave port and the address map.
`default_nettype none
`include "rss_defs.svh"
module rss_sequencer #(
   parameter int NTASK = 8,
   parameter int NIRQ  = 8,
   parameter int NL_AW = 10
) (
   // Clock and reset
   input  wire logic             CLK_IN,
   input  wire logic             RESET_N_IN,
   // AHB-Lite slave
   input  wire logic             HSEL_IN,
   input  wire logic [31:0]      HADDR_IN,
   input  wire logic [1:0]       HTRANS_IN,
   input  wire logic             HWRITE_IN,
   input  wire logic [2:0]       HSIZE_IN,
   input  wire logic [31:0]      HWDATA_IN,
   input  wire logic             HREADY_IN,
   output logic [31:0]           HRDATA_OUT,
   output logic                  HREADYOUT_OUT,
   output logic                  HRESP_OUT,
   // Power-up checks
   output logic                  CHECK_REQ_OUT,
   output logic [2:0]            CHECK_SEL_OUT,
   input  wire logic             CHECK_DONE_IN,
   input  wire logic             CHECK_FAIL_IN,
   // Memory card
   input  wire logic             CARD_PRESENT_IN,
   output logic                  CARD_CHK_REQ_OUT,
   input  wire logic             CARD_CHK_DONE_IN,
   input  wire logic             CARD_COPY_IN,
   // I/O refresh and program execution
   output logic                  IN_REF_REQ_OUT,
   input  wire logic             IN_REF_DONE_IN,
   output logic                  PROG_REQ_OUT,
   input  wire logic             PROG_DONE_IN,
   output logic                  OUT_REF_REQ_OUT,
   input  wire logic             OUT_REF_DONE_IN,
   // External output behaviour
   output logic                  OUT_PROG_OUT,
   output logic                  OUT_OFF_OUT,
   output logic                  OUT_HOLD_OUT,
   // Unscheduled communication
   input  wire logic             COMM_PEND_IN,
   output logic                  COMM_GRANT_OUT,
   input  wire logic             COMM_DONE_IN,
   // Configuration commands
   output logic                  CMD_REQ_OUT,
   output logic [2:0]            CMD_CODE_OUT,
   output logic [15:0]           CMD_ARG_OUT,
   // Tasks
   input  wire logic [NTASK-1:0] TASK_ENABLE_INSTR_IN,
   input  wire logic [NTASK-1:0] TASK_DISABLE_INSTR_IN,
   output logic [NTASK-1:0]      LOOP_TASK_RUN_OUT,
   input  wire logic [NIRQ-1:0]  IRQ_COND_IN,
   output logic [NIRQ-1:0]       INT_TASK_RUN_OUT,
   // Non-latched memory clear port
   output logic                  NL_WE_OUT,
   output logic [NL_AW-1:0]      NL_ADDR_OUT
);

   rss_pkg::rss_state_t  state_ff;
   rss_pkg::rss_state_t  nxt_state;
   logic [2:0]           step_ff;
   logic                 run_ff;
   logic                 nxt_run;
   logic                 init_done_ff;
   logic                 copy_ff;
   logic                 reject_ff;
   logic [31:0]          ctrl_ff;
   logic [NTASK-1:0]     task_mask_ff;
   logic                 clr_start;
   logic                 clr_busy;
   logic [NTASK-1:0]     task_en;
   // Bus pipeline
   logic                 wr_pend_ff;
   logic                 rd_pend_ff;
   logic [7:0]           addr_ff;
   logic                 addr_ok;
   logic                 wr_ctrl;
   logic                 wr_status;
   logic                 wr_cmd;
   logic                 wr_task;
   logic [31:0]          rd_mux;

   // Address phase accepted on a selected, ready NONSEQ or SEQ transfer of any size (HSIZE_IN is not decoded)
   assign addr_ok = HSEL_IN && HREADY_IN && HTRANS_IN[1];

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff    <= 8'h00;
      end else begin
         if (addr_ok) begin
            addr_ff <= HADDR_IN[7:0];
         end
         if (HREADY_IN) begin
            wr_pend_ff <= addr_ok && HWRITE_IN;
         end
         if (rd_pend_ff) begin
            rd_pend_ff <= 1'b0;
         end else begin
            rd_pend_ff <= addr_ok && !HWRITE_IN;
         end
      end
   end

   // Reads take one wait state so they see a write from the cycle before
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         HREADYOUT_OUT <= 1'b1;
         HRDATA_OUT    <= 32'h0000_0000;
         HRESP_OUT     <= 1'b0;
      end else begin
         HRESP_OUT <= 1'b0;
         if (addr_ok && !HWRITE_IN && !rd_pend_ff) begin
            HREADYOUT_OUT <= 1'b0;
         end else if (rd_pend_ff) begin
            HREADYOUT_OUT <= 1'b1;
            HRDATA_OUT    <= rd_mux;
         end
      end
   end

   // Write strobes land at the end of the data phase
   assign wr_ctrl   = wr_pend_ff && HREADY_IN && (addr_ff == `RSS_OFS_CTRL);
   assign wr_status = wr_pend_ff && HREADY_IN && (addr_ff == `RSS_OFS_STATUS);
   assign wr_cmd    = wr_pend_ff && HREADY_IN && (addr_ff == `RSS_OFS_CMD);
   assign wr_task   = wr_pend_ff && HREADY_IN && (addr_ff == `RSS_OFS_TASK);

   // Read mux; unmapped words read zero with an OKAY answer
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (addr_ff)
         `RSS_OFS_CTRL: begin
            rd_mux = ctrl_ff;
         end
         `RSS_OFS_STATUS: begin
            rd_mux[`RSS_ST_RUN]    = run_ff;
            rd_mux[`RSS_ST_INIT]   = init_done_ff;
            rd_mux[`RSS_ST_FAULT]  = (state_ff == rss_pkg::RSS_FAULT);
            rd_mux[`RSS_ST_REJECT] = reject_ff;
            rd_mux[`RSS_ST_CLEAR]  = clr_busy;
            rd_mux[`RSS_ST_COPY]   = copy_ff;
         end
         `RSS_OFS_TASK: begin
            rd_mux[NTASK-1:0] = task_en;
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   // Software control bits; only the defined bits are kept
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ctrl_ff <= `RSS_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_ff <= {29'h0000_0000, HWDATA_IN[2:0]};
      end
   end

   // Table and config rejected in RUN
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         CMD_REQ_OUT  <= 1'b0;
         CMD_CODE_OUT <= 3'h0;
         CMD_ARG_OUT  <= 16'h0000;
         reject_ff    <= 1'b0;
      end else begin
         CMD_REQ_OUT <= 1'b0;
         if (wr_cmd && run_ff && (HWDATA_IN[2:0] == `RSS_CMD_TABLE
                                  || HWDATA_IN[2:0] == `RSS_CMD_CFGINIT)) begin
            reject_ff <= 1'b1;
         end else begin
            if (wr_status && HWDATA_IN[`RSS_ST_REJECT]) begin
               reject_ff <= 1'b0;
            end
            if (wr_cmd && init_done_ff) begin
               CMD_REQ_OUT  <= 1'b1;
               CMD_CODE_OUT <= HWDATA_IN[2:0];
               CMD_ARG_OUT  <= HWDATA_IN[31:16];
            end
         end
      end
   end

   // Sequencer next state
   always_comb begin
      nxt_state = state_ff;
      nxt_run   = run_ff;
      clr_start = 1'b0;
      unique case (state_ff)
         rss_pkg::RSS_PWR_CLR: begin
            if (clr_busy && NL_ADDR_OUT == {NL_AW{1'b1}}) begin
               nxt_state = rss_pkg::RSS_CHECK;
            end
         end
         rss_pkg::RSS_CHECK: begin
            if (CHECK_DONE_IN && CHECK_FAIL_IN) begin
               nxt_state = rss_pkg::RSS_FAULT;
            end else if (CHECK_DONE_IN && step_ff == `RSS_CHECK_LAST) begin
               nxt_state = CARD_PRESENT_IN ? rss_pkg::RSS_CARD : rss_pkg::RSS_IN_REF;
            end
         end
         rss_pkg::RSS_CARD: begin
            if (CARD_CHK_DONE_IN) begin
               nxt_state = rss_pkg::RSS_IN_REF;
            end
         end
         // Failed check parks the block; only reset leaves it
         rss_pkg::RSS_FAULT: begin
            nxt_state = rss_pkg::RSS_FAULT;
         end
         rss_pkg::RSS_IN_REF: begin
            if (IN_REF_DONE_IN) begin
               nxt_state = run_ff ? rss_pkg::RSS_EXEC : rss_pkg::RSS_OUT_REF;
            end
         end
         rss_pkg::RSS_EXEC: begin
            if (PROG_DONE_IN) begin
               nxt_state = rss_pkg::RSS_OUT_REF;
            end
         end
         rss_pkg::RSS_OUT_REF: begin
            if (OUT_REF_DONE_IN) begin
               nxt_state = rss_pkg::RSS_COMM;
            end
         end
         rss_pkg::RSS_COMM: begin
            if (!COMM_PEND_IN || COMM_DONE_IN) begin
               nxt_state = rss_pkg::RSS_IN_REF;
               if (ctrl_ff[`RSS_CTRL_RUN] && !run_ff) begin
                  if (ctrl_ff[`RSS_CTRL_NLCLR]) begin
                     nxt_state = rss_pkg::RSS_RUN_CLR;
                     clr_start = 1'b1;
                  end else begin
                     nxt_run = 1'b1;
                  end
               end else if (!ctrl_ff[`RSS_CTRL_RUN] && run_ff) begin
                  nxt_run = 1'b0;
               end
            end
         end
         rss_pkg::RSS_RUN_CLR: begin
            if (!clr_busy && !clr_start) begin
               nxt_state = rss_pkg::RSS_IN_REF;
               nxt_run   = 1'b1;
            end
         end
         default: begin
            nxt_state = rss_pkg::RSS_FAULT;
         end
      endcase
   end

   // State, mode and check step
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         state_ff     <= rss_pkg::RSS_PWR_CLR;
         run_ff       <= 1'b0;
         step_ff      <= 3'h0;
         init_done_ff <= 1'b0;
         copy_ff      <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         run_ff   <= nxt_run;
         if (state_ff == rss_pkg::RSS_CHECK && CHECK_DONE_IN && !CHECK_FAIL_IN
             && step_ff != `RSS_CHECK_LAST) begin
            step_ff <= step_ff + 3'h1;
         end
         if (state_ff == rss_pkg::RSS_CARD && CARD_CHK_DONE_IN) begin
            copy_ff <= CARD_COPY_IN;
         end
         if (nxt_state == rss_pkg::RSS_IN_REF) begin
            init_done_ff <= 1'b1;
         end
      end
   end

   // Handshake levels follow the next state so they leave a flop
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         CHECK_REQ_OUT    <= 1'b0;
         CHECK_SEL_OUT    <= 3'h0;
         CARD_CHK_REQ_OUT <= 1'b0;
         IN_REF_REQ_OUT   <= 1'b0;
         PROG_REQ_OUT     <= 1'b0;
         OUT_REF_REQ_OUT  <= 1'b0;
         COMM_GRANT_OUT   <= 1'b0;
      end else begin
         CHECK_REQ_OUT    <= (nxt_state == rss_pkg::RSS_CHECK) && !CHECK_DONE_IN;
         CHECK_SEL_OUT    <= (state_ff == rss_pkg::RSS_CHECK && CHECK_DONE_IN)
                             ? step_ff + 3'h1 : step_ff;
         CARD_CHK_REQ_OUT <= (nxt_state == rss_pkg::RSS_CARD);
         IN_REF_REQ_OUT   <= (nxt_state == rss_pkg::RSS_IN_REF);
         PROG_REQ_OUT     <= (nxt_state == rss_pkg::RSS_EXEC);
         OUT_REF_REQ_OUT  <= (nxt_state == rss_pkg::RSS_OUT_REF);
         COMM_GRANT_OUT   <= (nxt_state == rss_pkg::RSS_COMM) && COMM_PEND_IN
                             && !COMM_DONE_IN;
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         OUT_PROG_OUT <= 1'b0;
         OUT_OFF_OUT  <= 1'b1;
         OUT_HOLD_OUT <= 1'b0;
      end else begin
         OUT_PROG_OUT <= nxt_run;
         OUT_OFF_OUT  <= !nxt_run && !ctrl_ff[`RSS_CTRL_HOLD];
         OUT_HOLD_OUT <= !nxt_run && ctrl_ff[`RSS_CTRL_HOLD];
      end
   end

   // Software loads the active mask; enable and disable instructions then set or clear single tasks
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         task_mask_ff <= '0;
      end else if (wr_task) begin
         task_mask_ff <= HWDATA_IN[NTASK-1:0];
      end
   end

   for (genvar i = 0; i < NTASK; i++) begin : g_task
      rss_task_gate u_gate (
         .clk_in      (CLK_IN),
         .reset_n_in  (RESET_N_IN),
         .load_in     (wr_task),
         .load_val_in (HWDATA_IN[i]),
         .on_in       (TASK_ENABLE_INSTR_IN[i] && run_ff),
         .off_in      (TASK_DISABLE_INSTR_IN[i] && run_ff),
         .enabled_out (task_en[i])
      );
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         LOOP_TASK_RUN_OUT <= '0;
         INT_TASK_RUN_OUT  <= '0;
      end else begin
         LOOP_TASK_RUN_OUT <= (nxt_state == rss_pkg::RSS_EXEC) ? task_en : '0;
         INT_TASK_RUN_OUT  <= nxt_run ? IRQ_COND_IN : '0;
      end
   end

   rss_nl_clear #(
      .AW (NL_AW)
   ) u_clear (
      .clk_in     (CLK_IN),
      .reset_n_in (RESET_N_IN),
      .start_in   (clr_start
                   || (state_ff == rss_pkg::RSS_PWR_CLR && !clr_busy)),
      .busy_out   (clr_busy),
      .we_out     (NL_WE_OUT),
      .addr_out   (NL_ADDR_OUT)
   );

endmodule
`default_nettype wire

// ### pkg/rss_defs.svh
// What this block does
// - After power-up, clear non-latched memory, run every check, download I/O settings.
// - With a memory card present, check whether the system copy must run.
// - Each scan refreshes inputs, runs the program in RUN only, then refreshes outputs.
// - In STOP the program is skipped but I/O refresh continues every scan.
// - In STOP table, configuration, program, check and bit forcing commands pass.
// - RUN executes the program, outputs follow it, table and config commands rejected.
// - In STOP loop and interrupt tasks halt; unexecuted loop tasks stay halted.
// - In RUN a loop task runs if active or enabled, not if disabled.
// - In RUN an interrupt task runs whenever its condition holds.
// - STOP to RUN clears or keeps non-latched memory by setting; latched kept.
// - RUN to STOP and STOP itself leave both memory areas untouched.
// - Unscheduled communication requests are serviced outside the scheduled refresh.
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

// Register byte offsets
`define RSS_OFS_CTRL     8'h00
`define RSS_OFS_STATUS   8'h04
`define RSS_OFS_CMD      8'h08
`define RSS_OFS_TASK     8'h0C

// Control register fields
`define RSS_CTRL_RUN     0
`define RSS_CTRL_NLCLR   1
`define RSS_CTRL_HOLD    2
`define RSS_CTRL_RST     32'h0000_0000

// Status register fields
`define RSS_ST_RUN       0
`define RSS_ST_INIT      1
`define RSS_ST_FAULT     2
`define RSS_ST_REJECT    3
`define RSS_ST_CLEAR     4
`define RSS_ST_COPY      5

// Command codes, low three bits of a command write
`define RSS_CMD_TABLE    3'h1
`define RSS_CMD_CFGINIT  3'h2
`define RSS_CMD_PROG     3'h3
`define RSS_CMD_CHECK    3'h4
`define RSS_CMD_FORCE    3'h5

// Index of the last power-up check; five checks, 0 to 4
`define RSS_CHECK_LAST   3'h4

`endif

// ### pkg/rss_pkg.sv
`default_nettype none
package rss_pkg;

   // Sequencer states
   typedef enum logic [3:0] {
      RSS_PWR_CLR,
      RSS_CHECK,
      RSS_CARD,
      RSS_FAULT,
      RSS_IN_REF,
      RSS_EXEC,
      RSS_OUT_REF,
      RSS_COMM,
      RSS_RUN_CLR
   } rss_state_t;

   // Power-up check selector on the check port
   typedef enum logic [2:0] {
      RSS_CHK_PROGRAM,
      RSS_CHK_CPU_PARAM,
      RSS_CHK_TABLE_PARAM,
      RSS_CHK_IO_COMPARE,
      RSS_CHK_IO_DOWNLOAD
   } rss_check_t;

endpackage
`default_nettype wire

// ### rtl/rss_nl_clear.sv
`default_nettype none
module rss_nl_clear #(
   parameter int AW = 10
) (
   input  wire logic          clk_in,
   input  wire logic          reset_n_in,
   input  wire logic          start_in,
   output logic               busy_out,
   output logic               we_out,
   output logic [AW-1:0]      addr_out
);

   // Walk every non-latched word once, writing zero
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         busy_out <= 1'b0;
         we_out   <= 1'b0;
         addr_out <= '0;
      end else if (start_in && !busy_out) begin
         busy_out <= 1'b1;
         we_out   <= 1'b1;
         addr_out <= '0;
      end else if (busy_out) begin
         if (addr_out == {AW{1'b1}}) begin
            busy_out <= 1'b0;
            we_out   <= 1'b0;
         end else begin
            addr_out <= addr_out + 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// ### rtl/rss_task_gate.sv
`default_nettype none
module rss_task_gate (
   input  wire logic clk_in,
   input  wire logic reset_n_in,
   input  wire logic load_in,
   input  wire logic load_val_in,
   input  wire logic on_in,
   input  wire logic off_in,
   output logic      enabled_out
);

   // Enable instruction beats disable in the same cycle; software load wins both
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         enabled_out <= 1'b0;
      end else if (load_in) begin
         enabled_out <= load_val_in;
      end else if (on_in) begin
         enabled_out <= 1'b1;
      end else if (off_in) begin
         enabled_out <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// ### test/rss_checker.sv
`default_nettype none
module rss_checker #(
   parameter int NIRQ  = 8,
   parameter int NL_AW = 10
) (
   // Clock and reset
   input wire logic             CLK_IN,
   input wire logic             RESET_N_IN,
   // Scan handshakes
   input wire logic             IN_REF_REQ_OUT,
   input wire logic             IN_REF_DONE_IN,
   input wire logic             PROG_REQ_OUT,
   input wire logic             OUT_REF_REQ_OUT,
   input wire logic             COMM_GRANT_OUT,
   // Mode, commands, tasks and clear port
   input wire logic             OUT_PROG_OUT,
   input wire logic             OUT_OFF_OUT,
   input wire logic             OUT_HOLD_OUT,
   input wire logic             CMD_REQ_OUT,
   input wire logic [2:0]       CMD_CODE_OUT,
   input wire logic [NIRQ-1:0]  IRQ_COND_IN,
   input wire logic [NIRQ-1:0]  INT_TASK_RUN_OUT,
   input wire logic             NL_WE_OUT,
   input wire logic [NL_AW-1:0] NL_ADDR_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   // One clock domain, so one default for all
   default clocking @(posedge CLK_IN);
   endclocking
   default disable iff (!RESET_N_IN);

   a_one_out_mode: assert property ($onehot({OUT_PROG_OUT, OUT_OFF_OUT, OUT_HOLD_OUT}))
      else $error("output behaviour not exactly one");
   a_prog_in_run: assert property (PROG_REQ_OUT |-> OUT_PROG_OUT)
      else $error("program requested outside RUN");
   a_int_halt_stop: assert property (!OUT_PROG_OUT |-> INT_TASK_RUN_OUT == '0)
      else $error("interrupt task running in STOP");
   a_int_follows: assert property (OUT_PROG_OUT && $past(OUT_PROG_OUT) |->
      INT_TASK_RUN_OUT == $past(IRQ_COND_IN)) else $error("interrupt task not following");
   a_in_before_prog: assert property ($rose(PROG_REQ_OUT) |->
      $past(IN_REF_REQ_OUT && IN_REF_DONE_IN)) else $error("program before input refresh");
   a_out_after_prog: assert property ($fell(PROG_REQ_OUT) |-> OUT_REF_REQ_OUT)
      else $error("program not followed by output refresh");
   a_comm_alone: assert property (COMM_GRANT_OUT |->
      !(IN_REF_REQ_OUT || PROG_REQ_OUT || OUT_REF_REQ_OUT)) else $error("grant inside refresh");
   a_mode_boundary: assert property ($changed(OUT_PROG_OUT) |->
      !PROG_REQ_OUT && !$past(PROG_REQ_OUT)) else $error("mode changed mid program");
   a_run_rejects: assert property (CMD_REQ_OUT && OUT_PROG_OUT && $past(OUT_PROG_OUT) |->
      !(CMD_CODE_OUT inside {3'h1, 3'h2})) else $error("refused command passed in RUN");
   a_sweep_steps: assert property (NL_WE_OUT && !(&NL_ADDR_OUT) |=>
      NL_WE_OUT && NL_ADDR_OUT == $past(NL_ADDR_OUT) + 1'h1) else $error("sweep skipped");
   a_stop_keeps: assert property ($fell(OUT_PROG_OUT) |-> !NL_WE_OUT [*8])
      else $error("memory cleared on RUN to STOP");
endmodule
bind rss_sequencer rss_checker #(.NIRQ(NIRQ), .NL_AW(NL_AW)) u_chk (.*);
`default_nettype wire

// ### test/rss_io_model.sv
`default_nettype none
module rss_io_model (
   // Clock, reset and pace
   input  wire logic       clk_in,
   input  wire logic       reset_n_in,
   input  wire logic       slow_in,
   // Requests: check, card, in, prog, out, comm
   input  wire logic [5:0] req_in,
   // Answers
   output logic [5:0]      done_out,
   output logic            fail_out,
   output logic            copy_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] wait_ff [6];
   logic       tog_ff;

   // Qualifiers toggle outside DONE so no stale value passes for an answer
   assign fail_out = done_out[5] ? 1'h0 : tog_ff;
   assign copy_out = done_out[4] ? 1'h1 : tog_ff;

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         done_out <= '0;
         tog_ff   <= 1'h0;
         for (int i = 0; i < 6; i++) wait_ff[i] <= 3'h0;
      end else begin
         tog_ff <= ~tog_ff;
         for (int i = 0; i < 6; i++) begin
            if (done_out[i] || !req_in[i]) begin
               done_out[i] <= 1'h0;
               wait_ff[i]  <= slow_in ? 3'($urandom_range(6, 1)) : 3'h0;
            end else if (wait_ff[i] == 3'h0) begin
               done_out[i] <= 1'h1;
            end else begin
               wait_ff[i] <= wait_ff[i] - 3'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### test/controller_run_stop_sequencer_bench.sv
`default_nettype none
module controller_run_stop_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NT = 8;
   localparam int NI = 8;
   localparam int AW = 3;
   `define BCHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
      $display("[ERR] %0t got %0h expected %0h", $time, (g), (e)); end end
   logic          clk = 1'h0, rst_n = 1'h0, hwrite = 1'h0, slow = 1'h0, rnd_on = 1'h0, card = 1'h1;
   logic          comm_pend = 1'h0, hready, hresp, chk_req, card_req, in_req, prog_req;
   logic          out_req, comm_grant, out_prog, out_off, out_hold, cmd_req, nl_we, fail, copy;
   logic [1:0]    htrans = 2'h0;
   logic [2:0]    chk_sel, cmd_code;
   logic [15:0]   cmd_arg;
   logic [31:0]   haddr = 32'h0, hwdata = 32'h0, hrdata, rd_q;
   logic [NT-1:0] en_i = '0, dis_i = '0, loop_run, mask, seen_mask, e, d;
   logic [NI-1:0] irq = '0, int_run;
   logic [AW-1:0] nl_addr;
   logic [5:0]    done;
   logic [18:0]   last_cmd;
   int            n_errors = 0, samples_checked = 0, n_sweep = 0, n_in = 0, n_prog = 0;
   int            n_chk = 0, n_card = 0, n_cmd = 0, mark, mark2;

   always #5 clk = ~clk;

   rss_sequencer #(.NTASK(NT), .NIRQ(NI), .NL_AW(AW)) uut (
      .CLK_IN(clk), .RESET_N_IN(rst_n), .HSEL_IN(1'h1), .HADDR_IN(haddr), .HTRANS_IN(htrans),
      .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
      .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
      .CHECK_REQ_OUT(chk_req), .CHECK_SEL_OUT(chk_sel), .CHECK_DONE_IN(done[5]),
      .CHECK_FAIL_IN(fail), .CARD_PRESENT_IN(card), .CARD_CHK_REQ_OUT(card_req),
      .CARD_CHK_DONE_IN(done[4]), .CARD_COPY_IN(copy), .IN_REF_REQ_OUT(in_req),
      .IN_REF_DONE_IN(done[3]), .PROG_REQ_OUT(prog_req), .PROG_DONE_IN(done[2]),
      .OUT_REF_REQ_OUT(out_req), .OUT_REF_DONE_IN(done[1]), .OUT_PROG_OUT(out_prog),
      .OUT_OFF_OUT(out_off), .OUT_HOLD_OUT(out_hold), .COMM_PEND_IN(comm_pend),
      .COMM_GRANT_OUT(comm_grant), .COMM_DONE_IN(done[0]), .CMD_REQ_OUT(cmd_req),
      .CMD_CODE_OUT(cmd_code), .CMD_ARG_OUT(cmd_arg), .TASK_ENABLE_INSTR_IN(en_i),
      .TASK_DISABLE_INSTR_IN(dis_i), .LOOP_TASK_RUN_OUT(loop_run), .IRQ_COND_IN(irq),
      .INT_TASK_RUN_OUT(int_run), .NL_WE_OUT(nl_we), .NL_ADDR_OUT(nl_addr));

   rss_io_model u_io (.clk_in(clk), .reset_n_in(rst_n), .slow_in(slow), .done_out(done),
      .req_in({chk_req, card_req, in_req, prog_req, out_req, comm_grant}),
      .fail_out(fail), .copy_out(copy));

   // Handshake scoreboard on pre-edge values
   always @(posedge clk) begin
      if (nl_we) n_sweep++;
      if (in_req && done[3]) n_in++;
      if (prog_req && done[2]) begin
         n_prog++;
         seen_mask = loop_run;
      end
      if (chk_req && done[5]) begin
         `BCHK(chk_sel, 3'(n_chk))
         n_chk++;
      end
      if (card_req && done[4]) n_card++;
      if (cmd_req) begin
         n_cmd++;
         last_cmd = {cmd_code, cmd_arg};
      end
   end

   // Background pending requests and interrupt conditions
   always @(posedge clk) begin
      if (rnd_on) begin
         comm_pend <= 1'($urandom);
         irq       <= NI'($urandom);
      end
   end

   function automatic logic cmd_ok(input logic [2:0] c, input logic run);
      return !(run && (c == 3'h1 || c == 3'h2));
   endfunction

   function automatic logic [NT-1:0] exp_mask(input logic [NT-1:0] m, en, dis);
      return (m & ~dis) | en;
   endfunction

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Every wait goes through here, so a hang always ends the run
   task automatic step(inout int n);
      @(negedge clk);
      n++;
      if (n > 2000) begin
         n_errors++;
         $display("[ERR] %0t wait ran out", $time);
         tally_and_finish();
      end
   endtask

   task automatic wait_ready();
      int n = 0;
      do step(n); while (hready !== 1'h1);
      @(posedge clk);
      rd_q = hrdata;
   endtask

   // Single AHB-Lite word transfer, read data lands in rd_q
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dat);
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {24'h0, a};
      wait_ready();
      htrans <= 2'h0;
      hwdata <= dat;
      wait_ready();
   endtask

   task automatic wait_mode(input logic v);
      int n = 0;
      do step(n); while (out_prog !== v);
      @(posedge clk);
   endtask

   task automatic wait_scans(input int k);
      int n = 0;
      int s = n_in;
      do step(n); while (n_in < s + k);
      @(posedge clk);
   endtask

   task automatic cmd_sweep(input logic run);
      logic [15:0] arg;
      int k;
      for (int c = 1; c <= 5; c++) begin
         arg = 16'($urandom);
         k = n_cmd;
         bus(1'h1, 8'h08, {arg, 13'h0, 3'(c)});
         repeat (3) @(posedge clk);
         `BCHK(n_cmd - k, int'(cmd_ok(3'(c), run)))
         if (cmd_ok(3'(c), run)) `BCHK(last_cmd, {3'(c), arg})
         bus(1'h0, 8'h04, 32'h0);
         `BCHK(rd_q[3], ~cmd_ok(3'(c), run))
         bus(1'h1, 8'h04, 32'h8);
      end
   endtask

   initial begin
      void'($urandom(64));
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      wait_scans(2);
      `BCHK(n_sweep, 1 << AW)
      `BCHK(n_chk, 5)
      `BCHK(n_card, 1)
      `BCHK(n_prog, 0)
      `BCHK({out_prog, out_off, out_hold}, 3'h2)
      bus(1'h0, 8'h04, 32'h0);
      `BCHK(rd_q, 32'h00000022)
      bus(1'h0, 8'h00, 32'h0);
      `BCHK(rd_q, 32'h00000000)
      bus(1'h1, 8'h10, $urandom);
      bus(1'h0, 8'h10, 32'h0);
      `BCHK(rd_q, 32'h00000000)
      `BCHK(hresp, 1'h0)
      $display("test power-up done");
      rnd_on <= 1'h1;
      cmd_sweep(1'h0);
      bus(1'h1, 8'h00, 32'h4);
      wait_scans(2);
      `BCHK({out_prog, out_off, out_hold}, 3'h1)
      `BCHK(int_run, '0)
      $display("test stop done");
      mask = NT'($urandom) | NT'(1);
      bus(1'h1, 8'h0C, 32'(mask));
      mark = n_sweep;
      bus(1'h1, 8'h00, 32'h3);
      wait_mode(1'h1);
      `BCHK(n_sweep - mark, 1 << AW)
      wait_scans(2);
      `BCHK(seen_mask, mask)
      cmd_sweep(1'h1);
      for (int i = 0; i < 4; i++) begin
         e = NT'($urandom);
         d = NT'($urandom);
         en_i  <= e;
         dis_i <= d;
         @(posedge clk);
         en_i  <= '0;
         dis_i <= '0;
         mask = exp_mask(mask, e, d);
         wait_scans(2);
         `BCHK(seen_mask, mask)
      end
      $display("test run done");
      // RUN to STOP under a slow partner
      slow <= 1'h1;
      mark = n_sweep;
      bus(1'h1, 8'h00, 32'h0);
      wait_mode(1'h0);
      mark2 = n_prog;
      wait_scans(3);
      `BCHK(n_sweep, mark)
      `BCHK(n_prog, mark2)
      `BCHK(int_run, '0)
      `BCHK({out_prog, out_off, out_hold}, 3'h2)
      bus(1'h1, 8'h00, 32'h1);
      wait_mode(1'h1);
      wait_scans(2);
      `BCHK(n_sweep, mark)
      `BCHK(seen_mask, mask)
      $display("test mode changes done");
      card  <= 1'h0;
      rst_n <= 1'h0;
      @(posedge clk);
      n_chk = 0;
      rst_n <= 1'h1;
      wait_scans(2);
      `BCHK(n_chk, 5)
      bus(1'h0, 8'h04, 32'h0);
      `BCHK(rd_q, 32'h00000002)
      $display("test reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
